// File: rtl/adc_seq_regs.svh
// Purpose: named constants of the serial converter control block
// Assumes: 100 MHz system clock
// Notes: command codes, fixed self-test results, timing counts
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

`define ADC_CLK_PERIOD_NS 10
`define ADC_FAST_CONV_NS 10000
`define ADC_SLOW_CONV_NS 40000
`define ADC_FAST_CYCLES ((`ADC_FAST_CONV_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)
`define ADC_SLOW_CYCLES ((`ADC_SLOW_CONV_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)

`define ADC_CMD_BITS 4
`define ADC_RES_BITS 10
`define ADC_FRAME_BITS 16
`define ADC_CMD_EDGES 5'h04
`define ADC_SAMPLE_EDGE 5'h04
`define ADC_LAST_EDGE 5'h0a
`define ADC_EDGE_SAT 5'h10

`define ADC_CMD_LAST_CHAN 4'h7
`define ADC_CMD_POWER_DOWN 4'h8
`define ADC_CMD_FAST 4'h9
`define ADC_CMD_SLOW 4'ha
`define ADC_CMD_TEST_MID 4'hb
`define ADC_CMD_TEST_LOW 4'hc
`define ADC_CMD_TEST_HIGH 4'hd

`define ADC_TEST_MID_VAL 10'h200
`define ADC_TEST_LOW_VAL 10'h000
`define ADC_TEST_HIGH_VAL 10'h3ff

`endif

// File: rtl/adc_seq_pkg.sv
// Purpose: shared types of the serial converter control block
// Assumes: nothing beyond the constants header
// Notes: one-hot conversion states
package adc_seq_pkg;
   typedef enum logic [1:0] {
      CONV_IDLE = 2'b01,
      CONV_RUN = 2'b10
   } conv_state_t;
endpackage

// File: rtl/sync_edge.sv
// Purpose: two-flop synchroniser with edge detection per bit
// Assumes: inputs asynchronous to clk
// Notes: edge detect reads only second and third stage
`timescale 1ns/1ns
`default_nettype none
module sync_edge #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] async,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_q;
         logic s2_q;
         logic s3_q;
         // first stage is read by the second stage only
         always_ff @(posedge clk) begin
            if (rst) begin
               s1_q <= 1'b1;
               s2_q <= 1'b1;
               s3_q <= 1'b1;
            end else begin
               s1_q <= async[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         end
         assign level[i] = s2_q;
         assign rise[i] = s2_q & ~s3_q;
         assign fall[i] = ~s2_q & s3_q;
      end
   endgenerate
endmodule // sync_edge
`default_nettype wire

// File: rtl/adc_serial_control_sequencer.sv
// Purpose: serial control and conversion sequencing of a 10-bit converter
// Assumes: serial pins asynchronous, sampled by clk; analog code on same clock
// Notes: serial clock edges are found by oversampling, so it must be slow vs clk
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_regs.svh"

// Operation
// R1: chip select fall resets counters and control, enables serial pins.
// R2: chip select rise stops input capture and releases the output driver.
// R3: trigger fall starts sampling; its rise holds and starts conversion.
// R4: trigger works regardless of serial clock and chip select; low time sets sampling.
// R5: processor mode captures 4 command bits MSB first on polarity-chosen edges.
// R6: frame mode captures 4 command bits after frame fall on opposite edges.
// R7: after four command bits the serial input is ignored until next frame.
// R8: output floats with chip select high, drives previous result otherwise.
// R9: processor mode: MSB at select fall, bits change on ten falling edges.
// R10: frame mode: MSB after frame fall, bits change on ten rising edges.
// R11: done goes low on tenth conversion edge and stays low while busy.
// R12: done goes high when the conversion finishes.
// R13: processor mode samples from fourth falling to tenth rising edge.
// R14: frame mode samples from fourth rising to tenth falling edge.
// R15: tenth conversion edge hands control to the internal state machine.
// R16: host supplies 10 to 16 serial clocks per transfer.
// R17: interface type latched from frame sync at chip select fall.
// R18: latched interface type selects clock edges and state machine reset.
// R19: processor hosts hold frame sync high.
// R20: command selects channel or test voltage, rate or power-down.
// R21: codes 0-7 channels, 8 power-down, 9 fast, A slow, E-F reserved.
// R22: self-test codes B, C, D give 200h, 000h, 3FFh.
// R23: frame mode supports 16 clocks, result padded with six zeros.
// R24: chip select fall aborts an ongoing cycle; result register is kept.
// R25: result register updates only when a conversion completes.
module adc_serial_control_sequencer
   import adc_seq_pkg::*;
#(
   parameter int RES_BITS = `ADC_RES_BITS,
   parameter int FRAME_BITS = `ADC_FRAME_BITS,
   parameter int FAST_CYCLES = `ADC_FAST_CYCLES,
   parameter int SLOW_CYCLES = `ADC_SLOW_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic chipSelectN,
   input wire logic ioClk,
   input wire logic dataIn,
   input wire logic frameSync,
   input wire logic sampleTriggerN,
   input wire logic clockPolaritySel,
   input wire logic [RES_BITS-1:0] adcCode,
   output logic dataOut,
   output logic dataOutEn,
   output logic eoc,
   output logic sampleEn,
   output logic [3:0] muxSel,
   output logic powerDown,
   output logic slowRate
);

   // refuse shapes the shifter cannot serve
   generate
      if (RES_BITS != `ADC_RES_BITS || FRAME_BITS <= RES_BITS || FAST_CYCLES < 1 || SLOW_CYCLES < FAST_CYCLES)
      begin : g_bad_param
         $error("unsupported parameter set");
      end
   endgenerate

   // all pins cross into clk through two flops
   logic [5:0] pinLvl;
   logic [5:0] pinRise;
   logic [5:0] pinFall;
   sync_edge #(.W(6)) i_sync_edge (
      .clk(clk),
      .rst(rst),
      .async({clockPolaritySel, sampleTriggerN, frameSync, dataIn, ioClk, chipSelectN}),
      .level(pinLvl),
      .rise(pinRise),
      .fall(pinFall)
   );

   logic csFall, csRise, clkRise, clkFall, fsLvl, fsFall, dinLvl, trigFall, trigRise, polLvl;
   assign csFall = pinFall[0];
   assign csRise = pinRise[0];
   assign clkRise = pinRise[1];
   assign clkFall = pinFall[1];
   assign dinLvl = pinLvl[2];
   assign fsLvl = pinLvl[3];
   assign fsFall = pinFall[3];
   assign trigFall = pinFall[4];
   assign trigRise = pinRise[4];
   assign polLvl = pinLvl[5];

   logic ifMode_q;        // 1 processor, 0 frame mode
   logic active_q;        // chip select low, I/O enabled
   logic framed_q;        // counting edges of a frame
   logic [4:0] cmdCnt_q;
   logic [4:0] cnvCnt_q;
   logic [4:0] shCnt_q;
   logic [`ADC_CMD_BITS-1:0] cmdSh_q;
   logic [FRAME_BITS-1:0] outSh_q;
   logic [RES_BITS-1:0] result_q;
   logic extMode_q;
   logic [3:0] convCmd_q;
   logic [31:0] convCnt_q;
   conv_state_t state_q;
   logic eoc_q, sampleEn_q, powerDown_q, slowRate_q, dataOutEn_q;
   logic [3:0] muxSel_q;

   // R17 R18: interface type from frame sync; edge roles follow it
   logic cnvEdge, shEdge, capEdge, frameStart, frameReset, counting;
   assign cnvEdge = ifMode_q ? clkRise : clkFall;
   assign shEdge = ifMode_q ? clkFall : clkRise;
   // R5 R6: capture edge set by polarity and interface type
   assign capEdge = (ifMode_q ~^ polLvl) ? clkRise : clkFall;
   assign frameStart = active_q && !ifMode_q && fsFall;
   // R18: frame mode restarts its state machine on clock fall with frame high
   assign frameReset = active_q && !ifMode_q && fsLvl && clkFall;
   assign counting = active_q && framed_q && !csRise;

   logic tenthEdge, fourthShEdge, cmdDone;
   // R15: tenth conversion edge passes control to the converter
   assign tenthEdge = counting && cnvEdge && cnvCnt_q == `ADC_LAST_EDGE - 5'h01;
   assign fourthShEdge = counting && shEdge && shCnt_q == `ADC_SAMPLE_EDGE - 5'h01;
   assign cmdDone = counting && capEdge && cmdCnt_q == `ADC_CMD_EDGES - 5'h01;

   // R1 R2: chip select opens and closes the serial port
   always_ff @(posedge clk) begin
      if (rst) begin
         active_q <= 1'b0;
         ifMode_q <= 1'b1;
      end else if (csFall) begin
         active_q <= 1'b1;
         // R17: latch the interface type
         ifMode_q <= fsLvl;
      end else if (csRise) begin
         active_q <= 1'b0;
      end
   end

   // frame framing: processor frames open at select fall, frame mode at sync fall
   always_ff @(posedge clk) begin
      if (rst) begin
         framed_q <= 1'b0;
      end else if (csFall) begin
         framed_q <= fsLvl;
      end else if (csRise || frameReset) begin
         framed_q <= 1'b0;
      end else if (frameStart) begin
         framed_q <= 1'b1;
      end
   end

   // R1: edge counters cleared at every frame start
   always_ff @(posedge clk) begin
      if (rst || csFall || frameStart || frameReset) begin
         cmdCnt_q <= 5'h00;
         cnvCnt_q <= 5'h00;
         shCnt_q <= 5'h00;
      end else if (counting) begin
         // R7: command counter saturates after four bits
         if (capEdge && cmdCnt_q != `ADC_CMD_EDGES) begin
            cmdCnt_q <= cmdCnt_q + 5'h01;
         end
         if (cnvEdge && cnvCnt_q != `ADC_EDGE_SAT) begin
            cnvCnt_q <= cnvCnt_q + 5'h01;
         end
         if (shEdge && shCnt_q != `ADC_EDGE_SAT) begin
            shCnt_q <= shCnt_q + 5'h01;
         end
      end
   end

   // R5 R6: command shift register, MSB first
   always_ff @(posedge clk) begin
      if (rst) begin
         cmdSh_q <= '0;
      end else if (counting && capEdge && cmdCnt_q != `ADC_CMD_EDGES) begin
         // R7: input ignored once four bits are in
         cmdSh_q <= {cmdSh_q[`ADC_CMD_BITS-2:0], dinLvl};
      end
   end

   // R20 R21: command decode on the fourth captured bit
   logic [3:0] newCmd;
   assign newCmd = {cmdSh_q[`ADC_CMD_BITS-2:0], dinLvl};
   always_ff @(posedge clk) begin
      if (rst) begin
         muxSel_q <= 4'h0;
         powerDown_q <= 1'b0;
         slowRate_q <= 1'b0;
      end else begin
         if (cmdDone) begin
            if (newCmd <= `ADC_CMD_LAST_CHAN || newCmd == `ADC_CMD_TEST_MID ||
                newCmd == `ADC_CMD_TEST_LOW || newCmd == `ADC_CMD_TEST_HIGH) begin
               muxSel_q <= newCmd;
            end
            // R21: rate codes
            if (newCmd == `ADC_CMD_FAST) begin
               slowRate_q <= 1'b0;
            end else if (newCmd == `ADC_CMD_SLOW) begin
               slowRate_q <= 1'b1;
            end
         end
         // power-down is left by any access, entered by its code
         if (cmdDone && newCmd == `ADC_CMD_POWER_DOWN) begin
            powerDown_q <= 1'b1;
         end else if (csFall) begin
            powerDown_q <= 1'b0;
         end
      end
   end

   // R8 R2: output driver enable follows chip select
   always_ff @(posedge clk) begin
      if (rst || csRise) begin
         dataOutEn_q <= 1'b0;
      end else if (csFall) begin
         dataOutEn_q <= 1'b1;
      end
   end

   // R9 R10 R23: result shifter, MSB first, zero padded to frame length
   always_ff @(posedge clk) begin
      if (rst) begin
         outSh_q <= '0;
      end else if (csFall || frameStart) begin
         // R8: previous result presented at frame start
         outSh_q <= {result_q, {(FRAME_BITS-RES_BITS){1'b0}}};
      end else if (counting && shEdge && shCnt_q < `ADC_LAST_EDGE) begin
         // ten shifts; afterwards only padding zeros remain
         outSh_q <= {outSh_q[FRAME_BITS-2:0], 1'b0};
      end
   end

   // R3 R4: extended sampling owns the sampler while the trigger is used
   always_ff @(posedge clk) begin
      if (rst) begin
         extMode_q <= 1'b0;
      end else if (trigFall) begin
         extMode_q <= 1'b1;
      end else if (csFall) begin
         extMode_q <= 1'b0;
      end
   end

   // sampling window: serial edges or trigger low time
   always_ff @(posedge clk) begin
      if (rst) begin
         sampleEn_q <= 1'b0;
      end else if (trigFall) begin
         // R3: trigger fall starts sampling; it wins over a select fall
         sampleEn_q <= 1'b1;
      end else if (trigRise || csFall) begin
         // R3: trigger rise holds the sample; select fall ends it too
         sampleEn_q <= 1'b0;
      end else if (!extMode_q && fourthShEdge) begin
         // R13 R14: normal sampling from fourth edge
         sampleEn_q <= 1'b1;
      end else if (!extMode_q && tenthEdge) begin
         sampleEn_q <= 1'b0;
      end
   end

   // conversion start from either source
   logic convStart;
   assign convStart = trigRise || (!extMode_q && tenthEdge);

   // R15 R24: conversion state machine; select fall aborts it
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= CONV_IDLE;
         convCnt_q <= '0;
         convCmd_q <= 4'h0;
      end else if (csFall && !trigRise) begin
         // R24: abort, result register untouched
         state_q <= CONV_IDLE;
      end else if (convStart) begin
         state_q <= CONV_RUN;
         convCnt_q <= '0;
         convCmd_q <= cmdDone ? newCmd : (cmdCnt_q == `ADC_CMD_EDGES ? cmdSh_q : muxSel_q);
      end else begin
         unique case (state_q)
            CONV_IDLE: convCnt_q <= '0;
            CONV_RUN: begin
               if (convCnt_q == 32'(slowRate_q ? SLOW_CYCLES - 1 : FAST_CYCLES - 1)) begin
                  state_q <= CONV_IDLE;
               end else begin
                  convCnt_q <= convCnt_q + 32'd1;
               end
            end
            default: state_q <= CONV_IDLE;
         endcase
      end
   end

   logic convEnd;
   assign convEnd = state_q == CONV_RUN && !convStart && !csFall &&
                    convCnt_q == 32'(slowRate_q ? SLOW_CYCLES - 1 : FAST_CYCLES - 1);

   // R25 R22: result written only at completion; test codes give fixed values
   always_ff @(posedge clk) begin
      if (rst) begin
         result_q <= '0;
      end else if (convEnd) begin
         unique case (convCmd_q)
            `ADC_CMD_TEST_MID: result_q <= `ADC_TEST_MID_VAL;
            `ADC_CMD_TEST_LOW: result_q <= `ADC_TEST_LOW_VAL;
            `ADC_CMD_TEST_HIGH: result_q <= `ADC_TEST_HIGH_VAL;
            default: begin
               // R21: power-down, rate and reserved codes give no result
               if (convCmd_q <= `ADC_CMD_LAST_CHAN) begin
                  result_q <= adcCode;
               end
            end
         endcase
      end
   end

   // R11 R12: done low while busy, high when the result is ready
   always_ff @(posedge clk) begin
      if (rst) begin
         eoc_q <= 1'b1;
      end else if (convStart) begin
         eoc_q <= 1'b0;
      end else if (convEnd || csFall) begin
         eoc_q <= 1'b1;
      end
   end

   assign dataOut = outSh_q[FRAME_BITS-1];
   assign dataOutEn = dataOutEn_q;
   assign eoc = eoc_q;
   assign sampleEn = sampleEn_q;
   assign muxSel = muxSel_q;
   assign powerDown = powerDown_q;
   assign slowRate = slowRate_q;

endmodule // adc_serial_control_sequencer
`default_nettype wire

// File: test/adc_seq_host.sv
// Purpose: host serial master model for the converter control block
// Assumes: serial clock of 80 ns, standing low outside frames
// Notes: a floated output reads as x so it never matches
`timescale 1ns/1ns
`default_nettype none
module adc_seq_host (
   input wire logic clk,
   input wire logic dataOut,
   input wire logic dataOutEn,
   output logic chipSelectN,
   output logic ioClk,
   output logic dataIn,
   output logic frameSync,
   output logic clockPolaritySel
);
   // idle pins
   initial begin
      chipSelectN = 1'b1;
      ioClk = 1'b0;
      dataIn = 1'b0;
      frameSync = 1'b1;
      clockPolaritySel = 1'b1;
   end

   // what the host sees on the result line
   function automatic logic seen();
      return dataOutEn ? dataOut : 1'bx;
   endfunction

   // one transfer; bits are sampled mid way through their stable half
   task automatic xfer(input logic pm, input logic pol, input logic [3:0] cmd, input int n,
                       output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge clk) #2;
      clockPolaritySel = pol;
      frameSync = pm;
      #40 chipSelectN = 1'b0;
      if (!pm) begin
         #60 frameSync = 1'b1;
         #60 frameSync = 1'b0;
      end
      #100;
      for (int i = 0; i < n; i++) begin
         #20;
         if (!pm) rx[15-i] = seen();
         dataIn = (i < 4) ? cmd[3-i] : ~dataIn;
         #20 ioClk = 1'b1;
         #20;
         if (pm) rx[15-i] = seen();
         #20 ioClk = 1'b0;
      end
      #40 chipSelectN = 1'b1;
      frameSync = 1'b1;
      dataIn = ~dataIn;
      #100;
   endtask
endmodule // adc_seq_host
`default_nettype wire

// File: test/adc_seq_asserts.sv
// Purpose: port checks of the converter control block
// Assumes: pins pass a two-flop synchroniser, two to three cycles late
// Notes: windows wait five cycles so sync delay never fires them
`timescale 1ns/1ns
`default_nettype none
module adc_seq_asserts #(
   parameter int SLOW_CYCLES = 4000
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic chipSelectN,
   input wire logic sampleTriggerN,
   input wire logic dataOutEn,
   input wire logic eoc,
   input wire logic sampleEn,
   input wire logic powerDown
);
   localparam int EOC_MAX = SLOW_CYCLES + 8;
   int busyCnt_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // busy length, counted since a range would be too long
   always_ff @(posedge clk) begin
      if (rst || eoc) begin
         busyCnt_q <= 0;
      end else begin
         busyCnt_q <= busyCnt_q + 1;
      end
   end

   property p_open;
      $fell(chipSelectN) ##1 (!chipSelectN) [*5] |-> dataOutEn;
   endproperty
   a_open: assert property (p_open) else $error("output not driven after select");
   property p_close;
      $rose(chipSelectN) ##1 chipSelectN [*5] |-> !dataOutEn;
   endproperty
   a_close: assert property (p_close) else $error("output still driven");
   property p_trig;
      $fell(sampleTriggerN) ##1 (!sampleTriggerN) [*5] |-> sampleEn;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger did not sample");
   property p_hold;
      $rose(sampleTriggerN) ##1 sampleTriggerN [*5] |-> !sampleEn && !eoc;
   endproperty
   a_hold: assert property (p_hold) else $error("trigger did not convert");
   property p_busy;
      $fell(eoc) |=> (!eoc) [*8];
   endproperty
   a_busy: assert property (p_busy) else $error("busy too short");
   property p_done;
      busyCnt_q <= EOC_MAX;
   endproperty
   a_done: assert property (p_done) else $error("conversion never ends");
   property p_handover;
      $fell(sampleEn) |-> ##[0:1] !eoc;
   endproperty
   a_handover: assert property (p_handover) else $error("hold without conversion");
   property p_wake;
      $fell(chipSelectN) ##1 (!chipSelectN) [*5] |-> !powerDown;
   endproperty
   a_wake: assert property (p_wake) else $error("power down kept");

   // main scenarios
   c_abort: cover property (!eoc ##1 $fell(chipSelectN));
   c_trig: cover property ($rose(sampleTriggerN) ##[1:8] !eoc);
   c_sleep: cover property ($rose(powerDown));
endmodule // adc_seq_asserts

bind adc_serial_control_sequencer adc_seq_asserts #(.SLOW_CYCLES(SLOW_CYCLES)) i_adc_seq_asserts (
   .clk(clk), .rst(rst), .chipSelectN(chipSelectN), .sampleTriggerN(sampleTriggerN),
   .dataOutEn(dataOutEn), .eoc(eoc), .sampleEn(sampleEn), .powerDown(powerDown));
`default_nettype wire

// File: test/tb_adc_serial_control_sequencer.sv
// Purpose: self-checking bench of the converter control block
// Assumes: conversion counts cut to 40 and 80 cycles
// Notes: each result is read back in the following transfer
`timescale 1ns/1ns
`default_nettype none
module tb_adc_serial_control_sequencer;
   localparam int FAST = 40;
   localparam int SLOW = 80;
   logic clk, rst, chipSelectN, ioClk, dataIn, frameSync, sampleTriggerN, clockPolaritySel;
   logic dataOut, dataOutEn, eoc, sampleEn, powerDown, slowRate;
   logic [9:0] adcCode, expRes;
   logic [3:0] muxSel;
   logic [15:0] rx;
   logic [31:0] seed = 32'h0000_0019;
   int numErrors = 0;
   int nTests = 0;
   int sampleCnt = 0;

   adc_serial_control_sequencer #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW)) i_adc_serial_control_sequencer (
      .clk(clk), .rst(rst), .chipSelectN(chipSelectN), .ioClk(ioClk), .dataIn(dataIn),
      .frameSync(frameSync), .sampleTriggerN(sampleTriggerN), .clockPolaritySel(clockPolaritySel),
      .adcCode(adcCode), .dataOut(dataOut), .dataOutEn(dataOutEn), .eoc(eoc), .sampleEn(sampleEn),
      .muxSel(muxSel), .powerDown(powerDown), .slowRate(slowRate));
   adc_seq_host i_adc_seq_host (
      .clk(clk), .dataOut(dataOut), .dataOutEn(dataOutEn), .chipSelectN(chipSelectN), .ioClk(ioClk),
      .dataIn(dataIn), .frameSync(frameSync), .clockPolaritySel(clockPolaritySel));

   // system clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // sampling cycles seen on the bench clock; frames take differences
   always @(posedge clk) begin
      if (sampleEn === 1'b1) sampleCnt <= sampleCnt + 1;
   end

   // normal sampling spans six link periods, half a period less or more by mode
   function automatic int sampleLen(input logic pm);
      return pm ? (6 * 80 - 40) / 10 : (6 * 80 + 40) / 10;
   endfunction

   // repeatable random source
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [9:0] nextRes(input logic [3:0] c, input logic [9:0] prev, input logic [9:0] code);
      case (c)
         4'hb: return 10'h200;
         4'hc: return 10'h000;
         4'hd: return 10'h3ff;
         default: return (c < 4'h8) ? code : prev;
      endcase
   endfunction

   task automatic chkWord(input logic [15:0] got, input logic [15:0] exp, input string what);
      nTests++;
      if (got !== exp) begin
         numErrors++;
         $display("unexpected %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic chkBit(input logic got, input logic exp, input string what);
      chkWord({15'h0000, got}, {15'h0000, exp}, what);
   endtask

   // bounded wait; a hang shows as a mismatch
   task automatic waitEoc();
      for (int k = 0; k < 300 && eoc !== 1'b1; k++) @(posedge clk) #2;
      chkBit(eoc, 1'b1, "conversion end");
      repeat (4) @(posedge clk);
   endtask

   // one transfer with random mode and polarity; random length in processor mode, 16 clocks in frame mode
   task automatic frame(input logic [3:0] c, input logic chk);
      logic [31:0] r;
      logic [15:0] ew;
      logic pm;
      int n;
      int s0;
      r = xs();
      pm = r[12];
      n = pm ? 10 + int'(r[15:13]) % 7 : 16;
      ew = {expRes, 6'h00} & ~(16'hffff >> n);
      s0 = sampleCnt;
      @(posedge clk) #2 adcCode = r[11:2];
      i_adc_seq_host.xfer(pm, r[16], c, n, rx);
      if (chk && pm) chkWord(rx, ew, "readback");
      if (chk && !pm) chkWord(rx, ew, "readback");
      if (pm) chkWord(16'(sampleCnt - s0), 16'(sampleLen(pm)), "sample time");
      if (!pm) chkWord(16'(sampleCnt - s0), 16'(sampleLen(pm)), "sample time");
      if (c < 4'h8 || (c > 4'ha && c < 4'he)) chkWord({12'h000, muxSel}, {12'h000, c}, "select");
      if (c == 4'h8) chkBit(powerDown, 1'b1, "power down");
      if (c == 4'h9 || c == 4'ha) chkBit(slowRate, c[1], "rate");
      waitEoc();
      expRes = nextRes(c, expRes, adcCode);
   endtask

   task automatic stopTest();
      $display("errors %0d checks %0d", numErrors, nTests);
      if (numErrors == 0 && nTests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // watchdog, well past the expected run
   initial begin
      #300000;
      numErrors++;
      stopTest();
   end

   // main sequence
   initial begin
      rst = 1'b1;
      sampleTriggerN = 1'b1;
      adcCode = 10'h000;
      expRes = 10'h000;
      repeat (8) @(posedge clk);
      #2 rst = 1'b0;
      repeat (4) @(posedge clk);
      // every code once, then random codes
      for (int k = 0; k < 24; k++) frame((k < 16) ? 4'(k) : 4'(xs()), k > 0);
      // abort mid conversion; reserved code then leaves old result
      @(posedge clk) #2 adcCode = ~expRes;
      i_adc_seq_host.xfer(1'b1, 1'b1, 4'h2, 10, rx);
      frame(4'he, 1'b1);
      frame(4'h5, 1'b1);
      // extended sampling while select is high
      @(posedge clk) #2 adcCode = ~expRes;
      sampleTriggerN = 1'b0;
      repeat (30) @(posedge clk);
      #2 chkBit(sampleEn, 1'b1, "sampling");
      sampleTriggerN = 1'b1;
      repeat (8) @(posedge clk);
      #2 chkBit(eoc, 1'b0, "busy");
      waitEoc();
      expRes = adcCode;
      frame(4'h0, 1'b1);
      frame(4'h1, 1'b1);
      stopTest();
   end
endmodule // tb_adc_serial_control_sequencer
`default_nettype wire
